/* tb/time_slot_afe_dig_int_config_tb.sv */
// Self-checking bench for the slot front-end configuration bank
`timescale 1ns/10ps
`default_nettype none
module time_slot_afe_dig_int_config_tb;
  import tsafe_pkg::*;
  logic        clk_in = 1'b0;     // Bench clock
  logic        nrst_in = 1'b0;    // Active-low reset
  logic [7:0]  addr_in = 8'h00;   // Host address
  logic        wr_en_in = 1'b0;   // Write strobe
  logic [15:0] wr_data_in = '0;   // Write data
  logic        rd_en_in = 1'b0;   // Read strobe
  logic [15:0] rd_data_out;       // Read data
  logic [4:0]  width, fine, gap;  // Window fields
  logic [5:0]  coarse, g234;      // Coarse delay, ch2-4 gain
  logic [7:0]  mode;              // Chain mode code
  logic [1:0]  bias, g1;          // Bias and ch1 gain
  logic        buf_o, acc_a, acc_b, gap_en, pr_a, pr_b, one_a, one_b; // Mode flags
  logic [3:0]  mask;              // Active channel mask
  logic [15:0] d;                 // Last read value
  int          fail_count = 0;    // Mismatches
  int          tests_run = 0;     // Comparisons
  logic [7:0]  ra [6] = '{ADDR_WINDOW, ADDR_FRONT, ADDR_GAIN234, ADDR_CHANSEL, ADDR_MODE_EN,
                           ADDR_OPTIONS}; // Mapped addresses
  logic [15:0] re [6] = '{{5'h4, 6'h17, 5'h1c}, {8'h1c, 2'b00, 2'h3, 2'h2, 2'h0}, 16'h0000,
                           16'h0020, 16'h0000, 16'h0000}; // Expected reset words
  logic [15:0] ov [4] = '{16'h0080, 16'h0040, 16'h0020, 16'h0000}; // Option patterns
  logic [15:0] mv [4] = '{16'h2000, 16'h1000, 16'h3000, 16'h0000}; // Mode patterns
  // Free-running 100 MHz clock
  always #5 clk_in = ~clk_in;
  tsafe_config u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wr_en_in(wr_en_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .slot_a_window_width_out(width),
    .slot_a_window_coarse_delay_out(coarse), .slot_a_window_fine_delay_out(fine),
    .slot_a_gap_len_out(gap), .slot_a_chain_mode_code_out(mode),
    .slot_a_integrator_buffer_out(buf_o), .slot_a_amp_bias_sel_out(bias),
    .slot_a_ch1_gain_out(g1), .slot_a_ch234_gain_out(g234),
    .slot_a_accum_mode_en_out(acc_a), .slot_b_accum_mode_en_out(acc_b),
    .accum_gap_enable_out(gap_en), .slot_a_pair_select_out(pr_a),
    .slot_b_pair_select_out(pr_b), .slot_a_one_channel_accum_out(one_a),
    .slot_b_one_channel_accum_out(one_b), .slot_a_active_channels_out(mask));
  // Compare with case equality so unknowns never match
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle write, then wait for the field flops to follow
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // One-cycle read, data taken after the following edge
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1;
    v = rd_data_out;
  endtask
  // Single exit point for pass, fail and hang
  task automatic conclude;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    // Reset words through the host port
    for (int i = 0; i < 6; i++)
    begin
      rd(ra[i], d);
      chk(d, re[i]);
    end
    chk({width, coarse, fine}, {5'h4, 6'h17, 5'h1c});
    chk({mode, bias, g1, buf_o}, {8'h1c, 2'h3, 2'h0, 1'b0});
    chk({gap, mask, g234}, {5'h00, 4'hf, 6'h00});
    chk({acc_b, acc_a, gap_en, pr_b, pr_a, one_b, one_a}, 7'h00);
    // Window width at maximum, coarse delay at zero, fine delay 0x15
    wr(ADDR_WINDOW, {5'h1f, 6'h00, 5'h15});
    chk({width, coarse, fine}, {5'h1f, 6'h00, 5'h15});
    // Gap and sample-pair options, one bit at a time
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_OPTIONS, ov[i]);
      chk({gap_en, gap}, {ov[i][7], ov[i][7] ? 5'h15 : 5'h00});
      chk({pr_b, pr_a}, ov[i][6:5]);
    end
    // Slot A accumulation enable also forces the integrator buffer
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_MODE_EN, mv[i]);
      chk({acc_b, acc_a, buf_o}, {mv[i][13], mv[i][12], mv[i][12]});
    end
    // Host sets accumulate code and reserved value one; gain is shared
    wr(ADDR_FRONT, {8'h1d, 2'b10, 2'h1, 2'h1, 2'h2});
    chk({mode, buf_o, bias}, {8'h1d, 1'b1, 2'h1});
    chk({g1, g234}, {2'h2, 6'h2a});
    rd(ADDR_FRONT, d);
    chk(d, {8'h1d, 2'b10, 2'h1, 2'h1, 2'h2});
    // Per-channel gain draws channels 2-4 from the gain register
    wr(ADDR_GAIN234, 16'h0027);
    wr(ADDR_FRONT, {8'h1c, 2'b01, 2'h0, 2'h1, 2'h3});
    chk({g1, g234, buf_o}, {2'h3, 6'h27, 1'b0});
    // One-channel bit only narrows the mask while slot A accumulates
    wr(ADDR_CHANSEL, 16'h4020);
    chk({one_b, one_a, mask}, {1'b0, 1'b1, 4'hf});
    wr(ADDR_MODE_EN, 16'h1000);
    chk(mask, 4'h1);
    wr(ADDR_CHANSEL, 16'h8020);
    chk({one_b, one_a, mask}, {1'b1, 1'b0, 4'hf});
    // Unmapped address: write ignored, read gives zero
    wr(8'h40, 16'hffff);
    rd(8'h40, d);
    chk(d, 16'h0000);
    rd(ADDR_FRONT, d);
    chk(d, {8'h1c, 2'b01, 2'h0, 2'h1, 2'h3});
    conclude();
  end
endmodule // time_slot_afe_dig_int_config_tb
`default_nettype wire

/* verilog/tsafe_config.sv */
// Slot front-end and integration-mode configuration bank behind the host port
// Operation
// - Bit 13 puts slot B in accumulation
// - Bit 12 puts slot A in accumulation
// - Bit 7 enables gap from fine delay
// - Bit 6 selects slot B single pair
// - Bit 5 selects slot A single pair
// - Slot A window width bits 15:11, 0x4
// - Slot A coarse delay bits 10:5, 0x17
// - Slot A fine delay bits 4:0, 0x1C
// - Chain mode code 0x1C means normal, default
// - Integrator buffered when bit set or slot A accumulating
// - Per-channel gain takes channels 2-4 from 0x55
// - Bias select bits 5:4, default code 3
// - Gain bits 1:0 shared unless per-channel
// - Slot A one-channel bit limits slot A accumulation to channel 1
`timescale 1ns/10ps
`default_nettype none
module tsafe_config
  import tsafe_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Host register port
  input  wire logic [7:0]  addr_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] wr_data_in,
  input  wire logic        rd_en_in,
  output logic      [15:0] rd_data_out,
  // Time slot A window
  output logic      [4:0]  slot_a_window_width_out,
  output logic      [5:0]  slot_a_window_coarse_delay_out,
  output logic      [4:0]  slot_a_window_fine_delay_out,
  output logic      [4:0]  slot_a_gap_len_out,
  // Time slot A front end
  output logic      [7:0]  slot_a_chain_mode_code_out,
  output logic             slot_a_integrator_buffer_out,
  output logic      [1:0]  slot_a_amp_bias_sel_out,
  output logic      [1:0]  slot_a_ch1_gain_out,
  output logic      [5:0]  slot_a_ch234_gain_out,
  // Integration mode
  output logic             slot_a_accum_mode_en_out,
  output logic             slot_b_accum_mode_en_out,
  output logic             accum_gap_enable_out,
  output logic             slot_a_pair_select_out,
  output logic             slot_b_pair_select_out,
  output logic             slot_a_one_channel_accum_out,
  output logic             slot_b_one_channel_accum_out,
  output logic      [3:0]  slot_a_active_channels_out
);
  // Address table, index order matches reset table
  localparam logic [7:0]  ADDRS [NREG] = '{ADDR_WINDOW, ADDR_FRONT, ADDR_GAIN234,
                                           ADDR_CHANSEL, ADDR_MODE_EN, ADDR_OPTIONS};
  localparam logic [15:0] RSTS  [NREG] = '{RST_WINDOW, RST_FRONT, RST_GAIN234,
                                           RST_CHANSEL, RST_MODE_EN, RST_OPTIONS};
  localparam int IX_WIN = 0;
  localparam int IX_FE  = 1;
  localparam int IX_G   = 2;
  localparam int IX_CH  = 3;
  localparam int IX_EN  = 4;
  localparam int IX_OPT = 5;

  logic [15:0] regs [NREG];      // Register contents
  logic [15:0] next_rd_data;     // Read mux result
  logic [15:0] win;              // Window timing register
  logic [15:0] fe;               // Front-end register
  logic [15:0] en;               // Mode enable register
  logic [15:0] opt;              // Option register
  logic [15:0] chs;              // Channel select register
  logic [15:0] g234;             // Channel 2-4 gain register
  // Derived outputs, next values
  logic        next_buf;
  logic [1:0]  next_ch1_gain;
  logic [5:0]  next_ch234_gain;
  logic [3:0]  next_active;
  logic [4:0]  next_gap;

  // Address decode used by write strobes and the read mux
  function automatic logic hit(input logic [7:0] a, input int i);
    hit = (a == ADDRS[i]);
  endfunction

  // One register per address; plain R/W, reserved bits stored as written
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      tsafe_reg16 #(.RESET_VALUE(RSTS[gi])) u_reg (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .wr_en_in  (wr_en_in && hit(addr_in, gi)),
        .wr_data_in(wr_data_in),
        .value_out (regs[gi])
      );
    end
  endgenerate

  assign win  = regs[IX_WIN];
  assign fe   = regs[IX_FE];
  assign en   = regs[IX_EN];
  assign opt  = regs[IX_OPT];
  assign chs  = regs[IX_CH];
  assign g234 = regs[IX_G];

  // Read mux; unmapped addresses read zero, previous data holds when idle
  always_comb
  begin
    next_rd_data = rd_data_out;
    if (rd_en_in)
    begin
      next_rd_data = 16'h0000;
      for (int i = 0; i < NREG; i++)
        if (hit(addr_in, i))
          next_rd_data = regs[i];
    end
  end

  // Derived steering of the analogue chain
  always_comb
  begin
    // Buffer forced whenever slot A accumulates, even if software left bit clear
    next_buf = fe[B_INT_BUF] | en[B_SLOTA_ACCUM];
    // Per-channel gain splits channel 1 from channels 2-4
    next_ch1_gain = fe[GAIN_HI:GAIN_LO];
    if (fe[B_PERCH])
      next_ch234_gain = g234[G234_HI:G234_LO];
    else
      next_ch234_gain = {3{fe[GAIN_HI:GAIN_LO]}};
    // One-channel option only matters while accumulating
    if (en[B_SLOTA_ACCUM] && chs[B_SLOTA_ONECH])
      next_active = CH_ONLY_1;
    else
      next_active = CH_ALL;
    // Gap length taken from fine delay only in gapped mode
    next_gap = opt[B_GAP] ? win[FINE_HI:FINE_LO] : 5'h00;
  end

  // Output registers; all outputs straight from flops
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      // Pins except rd_data_out and the active mask derive from the register reset table so they agree with read-back
      rd_data_out                    <= RST_RDATA;
      slot_a_window_width_out        <= RST_WINDOW[WIDTH_HI:WIDTH_LO];
      slot_a_window_coarse_delay_out <= RST_WINDOW[COARSE_HI:COARSE_LO];
      slot_a_window_fine_delay_out   <= RST_WINDOW[FINE_HI:FINE_LO];
      slot_a_gap_len_out             <= RST_OPTIONS[B_GAP] ? RST_WINDOW[FINE_HI:FINE_LO] : 5'h00;
      slot_a_chain_mode_code_out     <= RST_FRONT[MODE_HI:MODE_LO];
      slot_a_integrator_buffer_out   <= RST_FRONT[B_INT_BUF] | RST_MODE_EN[B_SLOTA_ACCUM];
      slot_a_amp_bias_sel_out        <= RST_FRONT[BIAS_HI:BIAS_LO];
      slot_a_ch1_gain_out            <= RST_FRONT[GAIN_HI:GAIN_LO];
      slot_a_ch234_gain_out          <= {3{RST_FRONT[GAIN_HI:GAIN_LO]}};
      slot_a_accum_mode_en_out       <= RST_MODE_EN[B_SLOTA_ACCUM];
      slot_b_accum_mode_en_out       <= RST_MODE_EN[B_SLOTB_ACCUM];
      accum_gap_enable_out           <= RST_OPTIONS[B_GAP];
      slot_a_pair_select_out         <= RST_OPTIONS[B_SLOTA_PAIR];
      slot_b_pair_select_out         <= RST_OPTIONS[B_SLOTB_PAIR];
      slot_a_one_channel_accum_out   <= RST_CHANSEL[B_SLOTA_ONECH];
      slot_b_one_channel_accum_out   <= RST_CHANSEL[B_SLOTB_ONECH];
      slot_a_active_channels_out     <= CH_ALL;
    end
    else
    begin
      rd_data_out                    <= next_rd_data;
      slot_a_window_width_out        <= win[WIDTH_HI:WIDTH_LO];
      slot_a_window_coarse_delay_out <= win[COARSE_HI:COARSE_LO];
      slot_a_window_fine_delay_out   <= win[FINE_HI:FINE_LO];
      slot_a_gap_len_out             <= next_gap;
      slot_a_chain_mode_code_out     <= fe[MODE_HI:MODE_LO];
      slot_a_integrator_buffer_out   <= next_buf;
      slot_a_amp_bias_sel_out        <= fe[BIAS_HI:BIAS_LO];
      slot_a_ch1_gain_out            <= next_ch1_gain;
      slot_a_ch234_gain_out          <= next_ch234_gain;
      slot_a_accum_mode_en_out       <= en[B_SLOTA_ACCUM];
      slot_b_accum_mode_en_out       <= en[B_SLOTB_ACCUM];
      accum_gap_enable_out           <= opt[B_GAP];
      slot_a_pair_select_out         <= opt[B_SLOTA_PAIR];
      slot_b_pair_select_out         <= opt[B_SLOTB_PAIR];
      slot_a_one_channel_accum_out   <= chs[B_SLOTA_ONECH];
      slot_b_one_channel_accum_out   <= chs[B_SLOTB_ONECH];
      slot_a_active_channels_out     <= next_active;
    end
  end

  // Assertions
  // Host write to one address; register takes it, field flop shows it next edge
  sequence s_host_write(logic [7:0] a);
    wr_en_in && (addr_in == a);
  endsequence

  // Buffer must follow accumulation even with the bit left clear
  a_buffer_forced: assert property (@(posedge clk_in) disable iff (!nrst_in)
    en[B_SLOTA_ACCUM] |=> slot_a_integrator_buffer_out)
    else $error("integrator not buffered in accumulation");
  a_slota_accum: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 slot_a_accum_mode_en_out == $past(en[B_SLOTA_ACCUM]))
    else $error("slot A accumulation enable mismatch");
  a_slotb_accum: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_host_write(ADDR_MODE_EN) |-> ##2
    slot_b_accum_mode_en_out == $past(wr_data_in[B_SLOTB_ACCUM], 2))
    else $error("slot B accumulation enable not applied");
  a_gap_len: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !opt[B_GAP] |=> slot_a_gap_len_out == 5'h00)
    else $error("gap present with gapped mode off");
  a_pair_b: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_host_write(ADDR_OPTIONS) |-> ##2
    slot_b_pair_select_out == $past(wr_data_in[B_SLOTB_PAIR], 2))
    else $error("slot B pair select not applied");
  a_pair_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_host_write(ADDR_OPTIONS) |-> ##2
    slot_a_pair_select_out == $past(wr_data_in[B_SLOTA_PAIR], 2))
    else $error("slot A pair select not applied");
  a_window_width: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_host_write(ADDR_WINDOW) |-> ##2
    slot_a_window_width_out == $past(wr_data_in[WIDTH_HI:WIDTH_LO], 2))
    else $error("window width not applied");
  a_coarse_fine: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 {slot_a_window_coarse_delay_out, slot_a_window_fine_delay_out}
    == $past(win[COARSE_HI:FINE_LO]))
    else $error("window delay mismatch");
  a_mode_code: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 slot_a_chain_mode_code_out == $past(fe[MODE_HI:MODE_LO]))
    else $error("chain mode code mismatch");
  a_split_gain: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fe[B_PERCH] |=> slot_a_ch234_gain_out == $past(g234[G234_HI:G234_LO]))
    else $error("channel 2-4 gain not from own register");
  // Shared mode: every channel carries the one gain code
  a_shared_gain: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !fe[B_PERCH] |=> (slot_a_ch1_gain_out == $past(fe[GAIN_HI:GAIN_LO]))
    && (slot_a_ch234_gain_out == {3{$past(fe[GAIN_HI:GAIN_LO])}}))
    else $error("shared gain mismatch");
  a_bias_sel: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ##1 slot_a_amp_bias_sel_out == $past(fe[BIAS_HI:BIAS_LO]))
    else $error("bias select mismatch");
  a_one_channel: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (en[B_SLOTA_ACCUM] && chs[B_SLOTA_ONECH]) |=> slot_a_active_channels_out == CH_ONLY_1)
    else $error("one-channel accumulation not applied");
  // Outside one-channel accumulation all four channels stay in use
  a_all_channels: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(en[B_SLOTA_ACCUM] && chs[B_SLOTA_ONECH]) |=> slot_a_active_channels_out == CH_ALL)
    else $error("channel mask narrowed outside one-channel accumulation");
endmodule // tsafe_config
`default_nettype wire

/* verilog/tsafe_pkg.sv */
// Register map, field layouts and reset values for the slot front-end config bank
package tsafe_pkg;
  // Register addresses on the host port
  localparam logic [7:0]  ADDR_WINDOW  = 8'h39;
  localparam logic [7:0]  ADDR_FRONT   = 8'h42;
  localparam logic [7:0]  ADDR_GAIN234 = 8'h55;
  localparam logic [7:0]  ADDR_CHANSEL = 8'h54;
  localparam logic [7:0]  ADDR_MODE_EN = 8'h58;
  localparam logic [7:0]  ADDR_OPTIONS = 8'h5a;
  // Reset values of whole registers
  localparam logic [15:0] RST_WINDOW   = 16'h22fc;
  localparam logic [15:0] RST_FRONT    = 16'h1c38;
  localparam logic [15:0] RST_GAIN234  = 16'h0000;
  localparam logic [15:0] RST_CHANSEL  = 16'h0020;
  localparam logic [15:0] RST_MODE_EN  = 16'h0000;
  localparam logic [15:0] RST_OPTIONS  = 16'h0000;
  // Field positions
  localparam int B_SLOTB_ACCUM = 13;
  localparam int B_SLOTA_ACCUM = 12;
  localparam int B_GAP         = 7;
  localparam int B_SLOTB_PAIR  = 6;
  localparam int B_SLOTA_PAIR  = 5;
  localparam int B_SLOTB_ONECH = 15;
  localparam int B_SLOTA_ONECH = 14;
  localparam int B_INT_BUF     = 7;
  localparam int B_PERCH       = 6;
  // Front-end mode codes
  localparam logic [7:0]  MODE_NORMAL = 8'h1c;
  localparam logic [7:0]  MODE_ACCUM  = 8'h1d;
  // Register count
  localparam int NREG = 6;
  // Field ranges, upper and lower bit
  localparam int WIDTH_HI  = 15;
  localparam int WIDTH_LO  = 11;
  localparam int COARSE_HI = 10;
  localparam int COARSE_LO = 5;
  localparam int FINE_HI   = 4;
  localparam int FINE_LO   = 0;
  localparam int MODE_HI   = 15;
  localparam int MODE_LO   = 8;
  localparam int BIAS_HI   = 5;
  localparam int BIAS_LO   = 4;
  localparam int GAIN_HI   = 1;
  localparam int GAIN_LO   = 0;
  localparam int G234_HI   = 5;
  localparam int G234_LO   = 0;
  // Active photodiode channel masks
  localparam logic [3:0]  CH_ONLY_1 = 4'h1;
  localparam logic [3:0]  CH_ALL    = 4'hf;
  // Read data before the first read
  localparam logic [15:0] RST_RDATA = 16'h0000;
endpackage : tsafe_pkg

/* verilog/tsafe_reg16.sv */
// One 16-bit read/write configuration register with reset value
`timescale 1ns/10ps
`default_nettype none
module tsafe_reg16
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // Write port
  input  wire logic        wr_en_in,
  input  wire logic [15:0] wr_data_in,
  // Stored value
  output logic      [15:0] value_out
);
  logic [15:0] next_value; // Next register content

  // Load on write, else hold
  always_comb
  begin
    next_value = wr_en_in ? wr_data_in : value_out;
  end

  // Storage
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      value_out <= RESET_VALUE;
    else
      value_out <= next_value;
  end
endmodule // tsafe_reg16
`default_nettype wire
